// ### pkg/monitor_alarm_pkg.sv
package monitor_alarm_pkg;

	// byte offsets within the register space
	localparam logic [7:0] ADDR_ALARM_FIRST = 8'h70;
	localparam logic [7:0] ADDR_ALARM_SECOND = 8'h71;
	localparam logic [7:0] ADDR_RSVD_FIRST = 8'h72;
	localparam logic [7:0] ADDR_RSVD_LAST = 8'h7E;
	localparam logic [7:0] ADDR_PAGE_SELECT = 8'h7F;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h88;

	// first alarm byte positions
	localparam int BIT_SUPPLY_LOW = 4;
	localparam int BIT_CHAN1_HIGH = 3;
	localparam int BIT_CHAN1_LOW = 2;
	localparam int BIT_CHAN2_HIGH = 1;
	localparam int BIT_CHAN2_LOW = 0;
	localparam int BIT_TEMP_HIGH = 7;
	localparam int BIT_TEMP_LOW = 6;
	localparam int BIT_SUPPLY_HIGH = 5;

	// second alarm byte positions
	localparam int BIT_CHAN3_HIGH = 7;
	localparam int BIT_CHAN3_LOW = 6;
	localparam int BIT_SUMMARY = 0;

	// enable mask positions, one per monitored quantity
	localparam int MASK_TEMP = 7;
	localparam int MASK_SUPPLY = 6;
	localparam int MASK_CHAN1 = 5;
	localparam int MASK_CHAN2 = 4;
	localparam int MASK_CHAN3 = 3;

	// page select field and the page holding the enable mask
	localparam int PAGE_LSB = 0;
	localparam int PAGE_W = 2;
	localparam logic [1:0] PAGE_RESET = 2'h0;
	localparam logic [1:0] PAGE_IRQ_ENABLE = 2'h1;

	localparam logic [7:0] IRQ_ENABLE_RESET = 8'hFF;
	localparam logic [7:0] RSVD_VALUE = 8'h00;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic IRQ_OE_RESET = 1'b0;

	typedef enum logic [1:0] {
		TABLE_00,
		TABLE_01,
		TABLE_02,
		TABLE_03
	} table_e;

	// one completed conversion: pulse plus comparison results
	typedef struct packed {
		logic done;
		logic above_high;
		logic below_low;
	} conv_result_s;

	// register access port as seen behind the two-wire serial engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

endpackage

// ### rtl/monitor_alarm_flags_table_select.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE_01 - bit 4 of byte 70h is set while supply is under its low limit.
// RULE_02 - bit 3 of byte 70h is set while monitor 1 is over its high limit.
// RULE_03 - bit 2 of byte 70h is set while monitor 1 is under its low limit.
// RULE_04 - bit 1 of byte 70h is set while monitor 2 is over its high limit.
// RULE_05 - bit 0 of byte 70h is set while monitor 2 is under its low limit.
// RULE_06 - bit 7 of byte 71h is set while monitor 3 is over its high limit.
// RULE_07 - bit 6 of byte 71h is set while monitor 3 is under its low limit.
// RULE_08 - bit 0 of byte 71h ORs all flags gated by the enable mask at 88h.
// RULE_09 - an all-zero enable mask holds the summary bit at zero.
// RULE_10 - bits 1:0 of byte 7Fh select table 00 to 03 for the paged space.
// RULE_11 - the host sets mask bits for wanted sources, all zero to disable.
// RULE_12 - an asserted summary shows on the first open-drain buffer output.
// RULE_13 - every finished conversion of a channel rewrites its flags; the supply high flag comes from i_supply_high_flag instead.
// RULE_14 - the table select field reads zero after reset.
module monitor_alarm_flags_table_select (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input var monitor_alarm_pkg::reg_req_s i_reg_req,
	output logic [7:0] o_reg_rdata,
	input var monitor_alarm_pkg::conv_result_s i_supply_conv,
	input var monitor_alarm_pkg::conv_result_s i_chan1_conv,
	input var monitor_alarm_pkg::conv_result_s i_chan2_conv,
	input var monitor_alarm_pkg::conv_result_s i_chan3_conv,
	input wire logic i_temp_high_flag,
	input wire logic i_temp_low_flag,
	input wire logic i_supply_high_flag,
	output logic [1:0] o_table_sel,
	output logic o_buf1_out,
	output logic o_buf1_oe
);

	logic supply_low_flag;
	logic chan1_high_flag;
	logic chan1_low_flag;
	logic chan2_high_flag;
	logic chan2_low_flag;
	logic chan3_high_flag;
	logic chan3_low_flag;
	logic masked_irq_summary;
	logic [7:0] irq_enable;
	monitor_alarm_pkg::table_e page_select;
	logic [7:0] alarm_flags_first;
	logic [7:0] alarm_flags_second;
	logic [7:0] next_rdata;
	logic page_is_mask;
	logic [7:0] irq_source;
	logic page_wr_hit;
	logic mask_wr_hit;

	// one flag pair per channel; flags follow the latest comparison only
	alarm_flag_pair u_supply_flags (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_conv(i_supply_conv),
		.o_high_flag(), // supply high comes from outside logic
		.o_low_flag(supply_low_flag) // [RULE_01] [RULE_13]
	);

	alarm_flag_pair u_chan1_flags (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_conv(i_chan1_conv),
		.o_high_flag(chan1_high_flag), // [RULE_02] [RULE_13]
		.o_low_flag(chan1_low_flag) // [RULE_03] [RULE_13]
	);

	alarm_flag_pair u_chan2_flags (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_conv(i_chan2_conv),
		.o_high_flag(chan2_high_flag), // [RULE_04] [RULE_13]
		.o_low_flag(chan2_low_flag) // [RULE_05] [RULE_13]
	);

	alarm_flag_pair u_chan3_flags (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_conv(i_chan3_conv),
		.o_high_flag(chan3_high_flag), // [RULE_06] [RULE_13]
		.o_low_flag(chan3_low_flag) // [RULE_07] [RULE_13]
	);

	always_comb begin
		alarm_flags_first = 8'h00;
		alarm_flags_first[monitor_alarm_pkg::BIT_TEMP_HIGH] =
			i_temp_high_flag;
		alarm_flags_first[monitor_alarm_pkg::BIT_TEMP_LOW] =
			i_temp_low_flag;
		alarm_flags_first[monitor_alarm_pkg::BIT_SUPPLY_HIGH] =
			i_supply_high_flag;
		alarm_flags_first[monitor_alarm_pkg::BIT_SUPPLY_LOW] =
			supply_low_flag; // [RULE_01]
		alarm_flags_first[monitor_alarm_pkg::BIT_CHAN1_HIGH] =
			chan1_high_flag; // [RULE_02]
		alarm_flags_first[monitor_alarm_pkg::BIT_CHAN1_LOW] =
			chan1_low_flag; // [RULE_03]
		alarm_flags_first[monitor_alarm_pkg::BIT_CHAN2_HIGH] =
			chan2_high_flag; // [RULE_04]
		alarm_flags_first[monitor_alarm_pkg::BIT_CHAN2_LOW] =
			chan2_low_flag; // [RULE_05]
	end

	// one bit per maskable source, placed like its enable bit; 2:0 stay 0
	always_comb begin
		irq_source = 8'h00;
		irq_source[monitor_alarm_pkg::MASK_TEMP] =
			i_temp_high_flag | i_temp_low_flag;
		irq_source[monitor_alarm_pkg::MASK_SUPPLY] =
			i_supply_high_flag | supply_low_flag;
		irq_source[monitor_alarm_pkg::MASK_CHAN1] =
			chan1_high_flag | chan1_low_flag;
		irq_source[monitor_alarm_pkg::MASK_CHAN2] =
			chan2_high_flag | chan2_low_flag;
		irq_source[monitor_alarm_pkg::MASK_CHAN3] =
			chan3_high_flag | chan3_low_flag;
	end

	// live mask of the current flags, so a zero mask forces 0
	assign masked_irq_summary =
		|(irq_source & irq_enable); // [RULE_08] [RULE_09]

	always_comb begin
		// bits 5:1 carry nothing and read 0
		alarm_flags_second = 8'h00;
		alarm_flags_second[monitor_alarm_pkg::BIT_CHAN3_HIGH] =
			chan3_high_flag; // [RULE_06]
		alarm_flags_second[monitor_alarm_pkg::BIT_CHAN3_LOW] =
			chan3_low_flag; // [RULE_07]
		alarm_flags_second[monitor_alarm_pkg::BIT_SUMMARY] =
			masked_irq_summary; // [RULE_08]
	end

	assign page_is_mask = (page_select == monitor_alarm_pkg::TABLE_01);

	// writes land only on 7Fh, or on 88h while table 01 is paged in
	assign page_wr_hit = i_reg_req.wr &&
		(i_reg_req.addr == monitor_alarm_pkg::ADDR_PAGE_SELECT);
	assign mask_wr_hit = i_reg_req.wr && page_is_mask &&
		(i_reg_req.addr == monitor_alarm_pkg::ADDR_IRQ_ENABLE);

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			page_select <= monitor_alarm_pkg::table_e'(
				monitor_alarm_pkg::PAGE_RESET); // [RULE_14]
		end else if (page_wr_hit) begin
			page_select <= monitor_alarm_pkg::table_e'(
				i_reg_req.wdata[monitor_alarm_pkg::PAGE_LSB +:
					monitor_alarm_pkg::PAGE_W]); // [RULE_10]
		end
	end

	// mask only reachable while table 01 is paged in; the host owns its value
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_enable <= monitor_alarm_pkg::IRQ_ENABLE_RESET;
		end else if (mask_wr_hit) begin
			irq_enable <= i_reg_req.wdata; // [RULE_10] [RULE_11]
		end
	end

	always_comb begin
		// unmapped or paged-out addresses read back as 00
		next_rdata = 8'h00;
		if (i_reg_req.addr == monitor_alarm_pkg::ADDR_ALARM_FIRST) begin
			next_rdata = alarm_flags_first;
		end else if (i_reg_req.addr ==
				monitor_alarm_pkg::ADDR_ALARM_SECOND) begin
			next_rdata = alarm_flags_second;
		end else if (i_reg_req.addr >= monitor_alarm_pkg::ADDR_RSVD_FIRST &&
				i_reg_req.addr <= monitor_alarm_pkg::ADDR_RSVD_LAST) begin
			next_rdata = monitor_alarm_pkg::RSVD_VALUE;
		end else if (i_reg_req.addr ==
				monitor_alarm_pkg::ADDR_PAGE_SELECT) begin
			next_rdata = {6'h00, page_select}; // [RULE_10]
		end else if (i_reg_req.addr ==
				monitor_alarm_pkg::ADDR_IRQ_ENABLE && page_is_mask) begin
			next_rdata = irq_enable; // [RULE_10]
		end
	end

	// read data holds until the next read so the serial engine can shift it
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_reg_rdata <= monitor_alarm_pkg::RDATA_RESET;
		end else if (i_reg_req.rd) begin
			o_reg_rdata <= next_rdata;
		end
	end

	// open drain: pulled low while the interrupt is pending
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_buf1_oe <= monitor_alarm_pkg::IRQ_OE_RESET;
		end else begin
			o_buf1_oe <= masked_irq_summary; // [RULE_12]
		end
	end

	assign o_buf1_out = 1'b0;
	assign o_table_sel = page_select; // [RULE_10]

endmodule

// one channel's flags, rewritten on every completed conversion
module alarm_flag_pair (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input var monitor_alarm_pkg::conv_result_s i_conv,
	output logic o_high_flag,
	output logic o_low_flag
);

	// not sticky: a flag drops once a conversion is back within limits
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_high_flag <= monitor_alarm_pkg::FLAG_RESET;
			o_low_flag <= monitor_alarm_pkg::FLAG_RESET;
		end else if (i_conv.done) begin
			o_high_flag <= i_conv.above_high; // [RULE_13]
			o_low_flag <= i_conv.below_low; // [RULE_13]
		end
	end

endmodule

`default_nettype wire

// ### verification/reg_host.sv
`timescale 1ns/1ps
`default_nettype none
module reg_host (
	input wire logic i_sys_clk,
	output var monitor_alarm_pkg::reg_req_s o_req,
	input wire logic [7:0] i_rdata
);
	initial o_req = '0;
	// idle bus shows inverted values so a stale address cannot pass
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_sys_clk) o_req <= '{1'b1, 1'b0, a, v};
		@(posedge i_sys_clk) o_req <= '{1'b0, 1'b0, ~a, ~v};
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_sys_clk) o_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge i_sys_clk) o_req <= '{1'b0, 1'b0, ~a, 8'h5A};
		// read data stands until the next read, so take it one edge later
		@(posedge i_sys_clk) v = i_rdata;
	endtask
endmodule
`default_nettype wire

// ### verification/alarm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_checker (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input var monitor_alarm_pkg::reg_req_s i_reg_req,
	input var monitor_alarm_pkg::conv_result_s i_chan3_conv,
	input wire logic [7:0] o_reg_rdata,
	input wire logic [1:0] o_table_sel,
	input wire logic o_buf1_out,
	input wire logic o_buf1_oe
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	wire logic wsel = i_reg_req.wr && i_reg_req.addr == 8'h7F;
	wire logic rd71 = i_reg_req.rd && i_reg_req.addr == 8'h71;
	// last comparison seen for monitor 3, the flags must follow it
	logic [1:0] chan3_seen;
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			chan3_seen <= 2'b00;
		end else if (i_chan3_conv.done) begin
			chan3_seen <= {i_chan3_conv.above_high, i_chan3_conv.below_low};
		end
	end
	a_sel_write: assert property (
		wsel |=> o_table_sel == $past(i_reg_req.wdata[1:0]))
		else $error("table select not taken");
	a_sel_hold: assert property (
		!wsel |=> $stable(o_table_sel)) else $error("table select moved");
	a_sel_read: assert property (
		i_reg_req.rd && i_reg_req.addr == 8'h7F |=>
		o_reg_rdata == {6'h00, $past(o_table_sel)})
		else $error("table select read wrong");
	a_rdata_hold: assert property (
		!i_reg_req.rd |=> $stable(o_reg_rdata)) else $error("read data moved");
	a_rsvd_zero: assert property (
		i_reg_req.rd && i_reg_req.addr inside {[8'h72:8'h7E]} |=>
		o_reg_rdata == 8'h00) else $error("reserved byte not zero");
	a_chan3_flags: assert property (
		rd71 |=> o_reg_rdata[7:6] == $past(chan3_seen))
		else $error("monitor 3 flags wrong");
	a_unused_zero: assert property (
		rd71 |=> o_reg_rdata[5:1] == 5'h00) else $error("unused bits set");
	a_summary_pin: assert property (
		rd71 |=> o_reg_rdata[0] == o_buf1_oe) else $error("pin disagrees");
	a_pin_low: assert property (
		o_buf1_out == 1'b0) else $error("open drain data not low");
endmodule
bind monitor_alarm_flags_table_select alarm_checker u_chk (
	.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_reg_req(i_reg_req),
	.i_chan3_conv(i_chan3_conv), .o_reg_rdata(o_reg_rdata),
	.o_table_sel(o_table_sel), .o_buf1_out(o_buf1_out), .o_buf1_oe(o_buf1_oe));
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_sys_clk = 0;
	logic i_rstn = 0;
	monitor_alarm_pkg::conv_result_s conv [4] = '{default: '0};
	monitor_alarm_pkg::reg_req_s req;
	logic [2:0] ext = 0;
	logic [7:0] rdata, d, e;
	logic [1:0] tsel;
	logic pin, oe;
	logic [3:0] hi = 0, lo = 0;
	logic [31:0] seed = 32'hBCFA, r;
	int errors = 0, num_checks = 0, mask;
	initial forever #5 i_sys_clk = ~i_sys_clk;
	reg_host host (.i_sys_clk(i_sys_clk), .o_req(req), .i_rdata(rdata));
	monitor_alarm_flags_table_select dut (.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn), .i_reg_req(req), .o_reg_rdata(rdata),
		.i_supply_conv(conv[0]), .i_chan1_conv(conv[1]),
		.i_chan2_conv(conv[2]), .i_chan3_conv(conv[3]),
		.i_temp_high_flag(ext[2]), .i_temp_low_flag(ext[1]),
		.i_supply_high_flag(ext[0]), .o_table_sel(tsel),
		.o_buf1_out(pin), .o_buf1_oe(oe));
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic summ();
		logic [4:0] s;
		s = {|ext[2:1], ext[0] | lo[0], hi[1] | lo[1],
			hi[2] | lo[2], hi[3] | lo[3]};
		return |(s & mask[7:3]);
	endfunction
	task chk(string n, logic [7:0] e, logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task close_out();
		if (errors == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#100000 errors++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge i_sys_clk);
		i_rstn <= 1;
		host.rd(8'h7F, d);
		chk("sel_reset", 8'h00, d);
		chk("tsel_reset", 8'h00, {6'h00, tsel});
		for (int p = 3; p >= 0; p--) begin
			host.wr(8'h7F, 8'hFC | 8'(p));
			host.rd(8'h7F, d);
			chk("sel", 8'(p), d);
			chk("tsel", 8'(p), {6'h00, tsel});
		end
		host.rd(8'h7E, d);
		chk("rsvd", 8'h00, d);
		host.wr(8'h7F, 8'h01);
		host.rd(8'h88, d);
		chk("mask_reset", monitor_alarm_pkg::IRQ_ENABLE_RESET, d);
		for (int i = 0; i < 60; i++) begin
			// every fourth pass clears the mask to disable the pin
			mask = (i % 4 == 0) ? 0 : xs() & 8'hFF;
			host.wr(8'h88, mask[7:0]);
			r = xs();
			@(posedge i_sys_clk);
			// some channels skip a conversion so their flags must hold
			for (int k = 0; k < 4; k++) begin
				conv[k] <= {r[12+k], r[2*k], r[2*k+1] & ~r[2*k]};
				if (r[12+k]) {hi[k], lo[k]} = {r[2*k], r[2*k+1] & ~r[2*k]};
			end
			ext <= r[10:8];
			@(posedge i_sys_clk);
			for (int k = 0; k < 4; k++) conv[k].done <= 1'b0;
			e = {ext, lo[0], hi[1], lo[1], hi[2], lo[2]};
			host.rd(8'h70, d);
			chk("alarm70", e, d);
			e = {hi[3], lo[3], 5'h00, summ()};
			host.rd(8'h71, d);
			chk("alarm71", e, d);
			chk("pin_oe", {7'h00, summ()}, {7'h00, oe});
			host.rd(8'h88, d);
			chk("mask", mask[7:0], d);
		end
		// with another table paged in, 88h is neither written nor read
		host.wr(8'h7F, 8'h02);
		host.wr(8'h88, 8'h5A);
		host.rd(8'h88, d);
		chk("mask_paged_out", 8'h00, d);
		host.wr(8'h7F, 8'h01);
		host.rd(8'h88, d);
		chk("mask_kept", mask[7:0], d);
		close_out();
	end
endmodule
`default_nettype wire
